// file: lpsp_port.sv
// Low-power asynchronous serial port: register slave, baud generator, transmitter, receiver.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module lpsp_port
  import lpsp_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port.
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        wr_stb_i,
  input  wire logic        rd_stb_i,
  output logic      [31:0] rd_data_o,
  // Serial line.
  input  wire logic        serial_in_pin_i,
  output logic             serial_out_pin_o
);

  // ==========================================================================
  // Register file.
  lpsp_ctrl1_t ctrl_q;
  lpsp_flags_t flags_q;
  lpsp_flags_t flags_d;
  logic [15:0] div_q;
  logic [1:0]  mode_q;
  logic [8:0]  comp_select_bits_q;
  logic        comp_sign_q;
  logic [7:0]  char_match_byte_q;
  logic [23:0] rx_timeout_threshold_q;
  logic [7:0]  tx_gap_count_q;
  logic [7:0]  txd_q;
  logic        tx_pend_q;
  logic [7:0]  rxd_q;
  logic [31:0] rdata_q;

  // Address decode.
  wire wr_c1  = wr_stb_i && addr_i == LPSP_CONTROL_ONE_ADDR;
  wire wr_c2  = wr_stb_i && addr_i == LPSP_CONTROL_TWO_ADDR;
  wire wr_cmp = wr_stb_i && addr_i == LPSP_COMP_ADDR;
  wire wr_st  = wr_stb_i && addr_i == LPSP_STATUS_ADDR;
  wire wr_txd = wr_stb_i && addr_i == LPSP_TX_DATA_ADDR;
  wire wr_rto = wr_stb_i && addr_i == LPSP_RX_TIMEOUT_VALUE_ADDR;
  wire wr_gap = wr_stb_i && addr_i == LPSP_TX_GAP_VALUE_ADDR;
  wire wr_mat = wr_stb_i && addr_i == LPSP_CHAR_MATCH_VALUE_ADDR;
  wire rd_rxd = rd_stb_i && addr_i == LPSP_RX_DATA_ADDR;
  wire en     = ctrl_q.enable;

  // Read selection; unmapped addresses read as zero.
  logic [31:0] rd_mux;
  assign rd_mux =
    (addr_i == LPSP_CONTROL_ONE_ADDR)      ? 32'(ctrl_q) :
    (addr_i == LPSP_CONTROL_TWO_ADDR)      ? {14'h0000, mode_q, div_q} :
    (addr_i == LPSP_COMP_ADDR)             ? {22'h000000, comp_sign_q, comp_select_bits_q} :
    (addr_i == LPSP_STATUS_ADDR)           ? {24'h000000, flags_q} :
    (addr_i == LPSP_RX_DATA_ADDR)          ? {24'h000000, rxd_q} :
    (addr_i == LPSP_TX_DATA_ADDR)          ? {24'h000000, txd_q} :
    (addr_i == LPSP_RX_TIMEOUT_VALUE_ADDR) ? {8'h00, rx_timeout_threshold_q} :
    (addr_i == LPSP_TX_GAP_VALUE_ADDR)     ? {24'h000000, tx_gap_count_q} :
    (addr_i == LPSP_CHAR_MATCH_VALUE_ADDR) ? {24'h000000, char_match_byte_q} :
    32'h00000000;

  // Configuration registers; they survive the enable bit going low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q                 <= '0;
      div_q                  <= LPSP_DIV_RESET;
      mode_q                 <= LPSP_MODE_OS16;
      comp_select_bits_q     <= 9'h000;
      comp_sign_q            <= 1'b0;
      char_match_byte_q      <= 8'h00;
      rx_timeout_threshold_q <= 24'h000000;
      tx_gap_count_q         <= 8'h00;
      txd_q                  <= 8'h00;
      rdata_q                <= 32'h00000000;
    end else begin
      if (wr_c1)  ctrl_q <= {23'h000000, wr_data_i[8:0]};
      if (wr_c2)  {mode_q, div_q} <= wr_data_i[LPSP_MODE_LSB+1:0];
      if (wr_cmp) {comp_sign_q, comp_select_bits_q} <= wr_data_i[LPSP_SIGN_BIT:0];
      if (wr_mat) char_match_byte_q <= wr_data_i[7:0];
      // (R17) 24-bit threshold.
      if (wr_rto) rx_timeout_threshold_q <= wr_data_i[23:0];
      if (wr_gap) tx_gap_count_q <= wr_data_i[7:0];
      if (wr_txd) txd_q <= wr_data_i[7:0];
      rdata_q <= rd_stb_i ? rd_mux : 32'h00000000;
    end
  end

  assign rd_data_o = rdata_q;

  // ==========================================================================
  // Baud generator: one prescaler per direction, channel 0 transmit, 1 receive.
  logic [3:0] first_smp;
  logic [3:0] last_smp;
  logic [1:0] restart;
  logic [1:0] comp_on;
  logic [1:0] smp_tick;
  logic [1:0] bit_end;
  logic [15:0] pre_q [2];
  logic [3:0]  smp_q [2];

  // (R8) (R18) Samples per bit by mode; single sample suits slow clocks; code 3 acts as 16x.
  assign last_smp  = (mode_q == LPSP_MODE_OS8) ? LPSP_OS8_LAST :
                     (mode_q == LPSP_MODE_OS1) ? 4'h0 : LPSP_OS16_LAST;
  assign first_smp = (mode_q == LPSP_MODE_OS8) ? LPSP_OS8_FIRST :
                     (mode_q == LPSP_MODE_OS1) ? 4'h0 : LPSP_OS16_FIRST;

  genvar g;
  for (g = 0; g < 2; g++) begin : g_baud
    wire        at_last = smp_q[g] == last_smp;
    wire [16:0] base    = {1'b0, div_q};
    // (R10) Last sample of a compensated bit gains one clock, or loses one unless the divisor is zero.
    wire [16:0] limit   = !(at_last && comp_on[g]) ? base :
                          !comp_sign_q ? base + 17'h00001 :
                          (div_q != 16'h0000) ? base - 17'h00001 : base;
    // (R9) A sample lasts divisor plus one clocks.
    assign smp_tick[g] = {1'b0, pre_q[g]} == limit;
    assign bit_end[g]  = smp_tick[g] && at_last;
    always_ff @(posedge clk_i) begin
      if (rst_i || restart[g]) begin
        pre_q[g] <= 16'h0000;
        smp_q[g] <= 4'h0;
      end else if (smp_tick[g]) begin
        pre_q[g] <= 16'h0000;
        smp_q[g] <= at_last ? 4'h0 : smp_q[g] + 4'h1;
      end else begin
        pre_q[g] <= pre_q[g] + 16'h0001;
      end
    end
  end

  // (R15) Frame shape shared by both directions.
  wire [2:0] last_bit = {1'b1, ctrl_q.data_length_sel};  // Index of the last data bit, 4 to 7.
  wire [7:0] dmask    = 8'hFF >> (2'h3 - ctrl_q.data_length_sel);

  // ==========================================================================
  // Transmitter.
  lpsp_tx_t   tx_q;
  logic [7:0] tx_sh_q;
  logic [2:0] tx_cnt_q;
  logic [7:0] tx_gcnt_q;
  logic       tx_stop2_q;
  logic       tx_out_q;
  logic       tx_par_q;
  logic       txc_set;
  logic       tx_load;
  wire        tx_tick = bit_end[0];

  assign restart[0] = !en;
  // (R11) Only data and parity bits take compensation.
  assign comp_on[0] = (tx_q == TX_DATA && comp_select_bits_q[tx_cnt_q]) ||
                      (tx_q == TX_PARITY && comp_select_bits_q[8]);
  wire tx_ready = tx_pend_q && ctrl_q.tx_en;
  // (R1) A held character moves to the shifter only from idle, end of stop or gap.
  assign tx_load = en && tx_tick && tx_ready && (tx_q == TX_IDLE ||
                   (tx_q == TX_GAP && tx_gcnt_q >= tx_gap_count_q) ||
                   (tx_q == TX_STOP && (tx_stop2_q || !ctrl_q.stop_count_sel) &&
                    tx_gap_count_q == 8'h00));
  // (R5) Flag rises as the stop bit begins.
  assign txc_set = tx_tick && (tx_q == TX_PARITY ||
                   (tx_q == TX_DATA && tx_cnt_q == last_bit && !ctrl_q.parity_enable));

  // Bit sequencer of the transmitter, stepping on the baud period.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      tx_q       <= TX_IDLE;
      tx_sh_q    <= 8'h00;
      tx_cnt_q   <= 3'h0;
      tx_gcnt_q  <= 8'h00;
      tx_stop2_q <= 1'b0;
      tx_out_q   <= 1'b1;
      tx_par_q   <= 1'b0;
    end else if (tx_load) begin
      // (R14) Start bit drives the line low.
      tx_q     <= TX_START;
      tx_sh_q  <= txd_q & dmask;
      // (R20) Parity over the data bits, inverted for odd.
      tx_par_q <= ^(txd_q & dmask) ^ ctrl_q.parity_odd;
      tx_out_q <= 1'b0;
    end else if (tx_tick) begin
      unique case (tx_q)
        TX_IDLE: tx_out_q <= 1'b1;
        TX_START: begin
          // (R13) Least significant bit first.
          tx_q     <= TX_DATA;
          tx_cnt_q <= 3'h0;
          tx_out_q <= tx_sh_q[0];
        end
        TX_DATA: begin
          if (tx_cnt_q == last_bit) begin
            tx_q       <= ctrl_q.parity_enable ? TX_PARITY : TX_STOP;
            tx_out_q   <= ctrl_q.parity_enable ? tx_par_q : 1'b1;
            tx_stop2_q <= 1'b0;
          end else begin
            tx_cnt_q <= tx_cnt_q + 3'h1;
            tx_out_q <= tx_sh_q[1];
            tx_sh_q  <= tx_sh_q >> 1;
          end
        end
        TX_PARITY: begin
          tx_q       <= TX_STOP;
          tx_out_q   <= 1'b1;
          tx_stop2_q <= 1'b0;
        end
        TX_STOP: begin
          // (R12) One or two stop bits.
          if (ctrl_q.stop_count_sel && !tx_stop2_q) begin
            tx_stop2_q <= 1'b1;
          end else begin
            // (R3) Gap of whole baud periods before the next start.
            tx_q      <= (tx_gap_count_q != 8'h00) ? TX_GAP : TX_IDLE;
            tx_gcnt_q <= 8'h01;
          end
        end
        TX_GAP: begin
          if (tx_gcnt_q >= tx_gap_count_q) begin
            tx_q <= TX_IDLE;
          end else begin
            tx_gcnt_q <= tx_gcnt_q + 8'h01;
          end
        end
      endcase
    end
  end

  // Holding register state: filled by software, emptied by a load.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      tx_pend_q <= 1'b0;
    end else begin
      tx_pend_q <= wr_txd || (tx_pend_q && !tx_load);
    end
  end

  assign serial_out_pin_o = tx_out_q;

  // ==========================================================================
  // Receiver.
  lpsp_rx_t   rx_q;
  logic [7:0] rx_sh_q;
  logic [2:0] rx_cnt_q;
  logic [2:0] maj_q;
  logic       rx_par_q;
  logic       rx_prev_q;
  wire        rx_tick = bit_end[1];
  wire        fall    = rx_prev_q && !serial_in_pin_i;
  wire        rx_go   = en && ctrl_q.rx_en && rx_q == RX_IDLE && fall;

  assign restart[1] = !en || rx_go;
  assign comp_on[1] = (rx_q == RX_DATA && comp_select_bits_q[rx_cnt_q]) ||
                      (rx_q == RX_PARITY && comp_select_bits_q[8]);

  // (R19) Three centre samples vote; in single-sample mode one mid-bit sample fills all.
  wire [2:0] maj_now = {smp_q[1] == first_smp + 4'h2 ? serial_in_pin_i : maj_q[2],
                        smp_q[1] == first_smp + 4'h1 ? serial_in_pin_i : maj_q[1],
                        smp_q[1] == first_smp ? serial_in_pin_i : maj_q[0]};
  wire [2:0] maj_d   = (mode_q == LPSP_MODE_OS1) ? {3{serial_in_pin_i}} : maj_now;
  wire       cap     = (mode_q == LPSP_MODE_OS1) ? pre_q[1] == (div_q >> 1) : smp_tick[1];
  wire       vote    = (maj_q[0] & maj_q[1]) | (maj_q[0] & maj_q[2]) | (maj_q[1] & maj_q[2]);
  wire       rx_done = rx_tick && rx_q == RX_STOP;
  wire [7:0] rx_char = rx_sh_q >> (2'h3 - ctrl_q.data_length_sel);

  // Sample capture and line history for start detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      maj_q     <= 3'h7;
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= serial_in_pin_i;
      if (cap) maj_q <= maj_d;
    end
  end

  // Bit sequencer of the receiver.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      rx_q     <= RX_IDLE;
      rx_sh_q  <= 8'h00;
      rx_cnt_q <= 3'h0;
      rx_par_q <= 1'b0;
    end else if (rx_go) begin
      rx_q <= RX_START;
    end else if (rx_tick) begin
      unique case (rx_q)
        RX_IDLE: rx_q <= RX_IDLE;
        RX_START: begin
          rx_q     <= vote ? RX_IDLE : RX_DATA;
          rx_cnt_q <= 3'h0;
        end
        RX_DATA: begin
          rx_sh_q  <= {vote, rx_sh_q[7:1]};
          rx_cnt_q <= rx_cnt_q + 3'h1;
          if (rx_cnt_q == last_bit) begin
            rx_q <= ctrl_q.parity_enable ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY: begin
          rx_par_q <= vote;
          rx_q     <= RX_STOP;
        end
        // (R22) Only the first stop bit is looked at, then back to idle.
        RX_STOP: rx_q <= RX_IDLE;
      endcase
    end
  end

  // (R2) Completed character lands in the receive data register; overrun keeps the old one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_q <= 8'h00;
    end else if (rx_done && !flags_q.rx_ready) begin
      rxd_q <= rx_char;
    end
  end

  // ==========================================================================
  // Receive timeout counter in baud periods of the free-running transmit prescaler.
  logic [23:0] to_cnt_q;
  wire  [23:0] to_next  = to_cnt_q + 24'h000001;
  wire         rto_rise = wr_c1 && wr_data_i[8] && !ctrl_q.rx_timeout_enable;
  // (R23) Flag when the count reaches the threshold.
  wire         to_set   = en && ctrl_q.rx_timeout_enable && tx_tick &&
                          rx_timeout_threshold_q != 24'h000000 &&
                          to_next == rx_timeout_threshold_q;

  // (R21) Restart on each start bit and when the timeout is switched on.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en || rx_go || rto_rise) begin
      to_cnt_q <= 24'h000000;
    end else if (ctrl_q.rx_timeout_enable && tx_tick &&
                 to_cnt_q != rx_timeout_threshold_q) begin
      to_cnt_q <= to_next;
    end
  end

  // ==========================================================================
  // Status flags other than tx_empty: set wins over clear; clear by writing one, or by the data access.
  lpsp_flags_t fset;
  lpsp_flags_t fclr;
  // (R16) Receive error detection.
  assign fset = {rx_done && rx_char == char_match_byte_q,       // (R24) match
                 to_set,
                 rx_done && flags_q.rx_ready,
                 rx_done && ctrl_q.parity_enable &&
                   (rx_par_q != (^(rx_char & dmask) ^ ctrl_q.parity_odd)),
                 rx_done && !vote,
                 rx_done,
                 1'b0,
                 txc_set};
  assign fclr = (wr_st ? lpsp_flags_t'(wr_data_i[7:0]) : 8'h00) |
                {2'b00, 3'b000, rd_rxd, 1'b0, wr_txd};
  assign flags_d = {(flags_q[7:2] & ~fclr[7:2]) | fset[7:2], !tx_pend_q,
                    (flags_q.tx_complete_flag & ~fclr[0]) | fset[0]};

  // (R4) Enable low returns every flag to its reset value.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      flags_q <= LPSP_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_stop_begins;
    txc_set && en;
  endsequence

  chk_disable_quiets: assert property (!en |=> tx_out_q && flags_q == LPSP_FLAGS_RESET) // R4
    else $error("disabled port not quiet");
  chk_txc_at_stop: assert property (s_stop_begins |=> tx_q == TX_STOP && tx_out_q
                                    && flags_q.tx_complete_flag) // R5
    else $error("transmit complete not set at stop");
  chk_load_after_out: assert property (tx_load |-> tx_q inside {TX_IDLE, TX_STOP, TX_GAP}) // R1
    else $error("shifter loaded mid character");
  chk_start_low: assert property (tx_load |=> tx_q == TX_START && !tx_out_q) // R14
    else $error("start bit not low");
  chk_gap_honoured: assert property (en && $rose(tx_q == TX_GAP) |-> tx_gap_count_q != 8'h00) // R3
    else $error("gap entered with zero gap");
  chk_parity_out: assert property (en && tx_q == TX_PARITY |-> tx_out_q == tx_par_q) // R20
    else $error("parity bit wrong on line");
  chk_rx_moves: assert property (en && rx_done && !flags_q.rx_ready |=> rxd_q == $past(rx_char)
                                 && flags_q.rx_ready) // R2
    else $error("received byte not stored");
  chk_frame_err: assert property (en && rx_done && !vote |=> flags_q.framing_error_flag) // R19
    else $error("bad stop bit not flagged");
  chk_timeout_flag: assert property (to_set |=> flags_q.rx_timeout) // R23
    else $error("timeout not flagged");
  chk_char_match: assert property (en && rx_done && rx_char == char_match_byte_q
                                   |=> flags_q.char_match) // R24
    else $error("character match not flagged");

endmodule : lpsp_port
`default_nettype wire

// file: lpsp_pkg.sv
// Constants, register map and carrier types of the low-power asynchronous serial port.
//
// Functional notes
// (R1) Load shifter only after previous character finishes.
// (R2) At stop bit, move shifter to receive data.
// (R3) Wait gap times baud period before next start.
// (R4) Enable low aborts, resets flags, keeps configuration.
// (R5) Transmit-complete flag set at stop bit.
// (R6) Software writes data only after transmit-complete reads one.
// (R7) Bus clock no slower than kernel clock.
// (R8) Sampling modes: 16x, 8x and single sample.
// (R9) Sample rate is clock over divisor plus one.
// (R10) Compensated bit gains or loses one clock; the code loses none when the divisor is zero.
// (R11) Nine selects: data bits and parity only.
// (R12) Start, 5-8 data, parity option, 1-2 stops.
// (R13) LSB first, parity after last data bit.
// (R14) Idle high, falling edge starts, back-to-back allowed.
// (R15) One shared frame setting for both directions.
// (R16) Receiver flags framing, overrun and parity errors.
// (R17) Receive timeout threshold is 24 bits wide.
// (R18) Serves 9600 bit/s from a 32.768 kHz clock.
// (R19) 16x majority of samples 8-10; bad stop flags.
// (R20) Even parity XOR of data, odd inverted.
// (R21) Timeout counts baud periods from start or enable.
// (R22) Receiver uses first stop bit only.
// (R23) Timeout reaching threshold sets a status flag.
// (R24) Received byte equal to match value sets flag.
package lpsp_pkg;

  // ==========================================================================
  // Register byte addresses.
  localparam logic [31:0] LPSP_CONTROL_ONE_ADDR      = 32'h40005C00;
  localparam logic [31:0] LPSP_CONTROL_TWO_ADDR      = 32'h40005C04;
  localparam logic [31:0] LPSP_COMP_ADDR             = 32'h40005C08;
  localparam logic [31:0] LPSP_STATUS_ADDR           = 32'h40005C0C;
  localparam logic [31:0] LPSP_RX_DATA_ADDR          = 32'h40005C10;
  localparam logic [31:0] LPSP_TX_DATA_ADDR          = 32'h40005C14;
  localparam logic [31:0] LPSP_RX_TIMEOUT_VALUE_ADDR = 32'h40005C18;
  localparam logic [31:0] LPSP_TX_GAP_VALUE_ADDR     = 32'h40005C1C;
  localparam logic [31:0] LPSP_CHAR_MATCH_VALUE_ADDR = 32'h40005C2C;

  // ==========================================================================
  // Field positions and codes.
  localparam int          LPSP_MODE_LSB   = 16;
  localparam int          LPSP_SIGN_BIT   = 9;
  localparam logic [1:0]  LPSP_MODE_OS16  = 2'h0;
  localparam logic [1:0]  LPSP_MODE_OS8   = 2'h1;
  localparam logic [1:0]  LPSP_MODE_OS1   = 2'h2;
  localparam logic [3:0]  LPSP_OS16_FIRST = 4'h7;
  localparam logic [3:0]  LPSP_OS8_FIRST  = 4'h3;
  localparam logic [3:0]  LPSP_OS16_LAST  = 4'hF;
  localparam logic [3:0]  LPSP_OS8_LAST   = 4'h7;
  localparam logic [15:0] LPSP_DIV_RESET  = 16'h0000;

  // ==========================================================================
  // Carrier types.
  typedef struct packed {
    logic [22:0] rsvd;
    logic        rx_timeout_enable;
    logic        stop_count_sel;
    logic        parity_odd;
    logic        parity_enable;
    logic [1:0]  data_length_sel;
    logic        rx_en;
    logic        tx_en;
    logic        enable;
  } lpsp_ctrl1_t;

  typedef struct packed {
    logic char_match;
    logic rx_timeout;
    logic overrun;
    logic parity_err;
    logic framing_error_flag;
    logic rx_ready;
    logic tx_empty;
    logic tx_complete_flag;
  } lpsp_flags_t;

  localparam lpsp_flags_t LPSP_FLAGS_RESET = 8'h03;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_GAP} lpsp_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} lpsp_rx_t;

endpackage : lpsp_pkg

// file: lpsp_peer.sv
// Remote serial transceiver model that faces the port on its line side.
`timescale 1ns/100ps
`default_nettype none
module lpsp_peer (
  // Clock and line.
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  int         bt = 16;
  int         cyc;
  logic [7:0] d;
  logic [8:0] got_q[$];
  int         st_q[$];

  // Free cycle count that stamps the start of each received frame.
  always @(posedge clk_i) cyc++;

  // ==========================================================
  // One bit period on the line, held from a rising edge.
  task automatic put(input logic v);
    line_o <= v;
    repeat (bt) @(posedge clk_i);
  endtask : put

  task automatic send(input logic [7:0] b, input int nb, input logic pe, od, bp, bs);
    logic p;
    p = od ^ bp;
    @(posedge clk_i);
    put(1'b0);
    for (int i = 0; i < nb; i++) begin
      put(b[i]);
      p ^= b[i];
    end
    if (pe) put(p);
    put(!bs);
    line_o <= 1'b1;
  endtask : send

  initial begin
    line_o = 1'b1;
    forever begin
      @(negedge line_i);
      st_q.push_back(cyc);
      repeat (bt / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bt) @(posedge clk_i);
        d[i] = line_i;
      end
      repeat (bt) @(posedge clk_i);
      got_q.push_back({line_i, d});
    end
  end
endmodule : lpsp_peer
`default_nettype wire

// file: lpsp_port_tb.sv
// Self-checking testbench of the low-power asynchronous serial port.
`timescale 1ns/100ps
`default_nettype none
module lpsp_port_tb import lpsp_pkg::*;;
  logic        clk, rst, ws, rs, sin, sout;
  logic [31:0] addr, wd, rdat, seed, d, ex;
  logic [7:0]  b, b2, mv, txq[$];
  int          fail_count, n_tests, dl, k;

  lpsp_port u_dut (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wr_data_i(wd), .wr_stb_i(ws),
    .rd_stb_i(rs), .rd_data_o(rdat), .serial_in_pin_i(sin), .serial_out_pin_o(sout));
  lpsp_peer u_peer (.clk_i(clk), .line_i(sout), .line_o(sin));

  // ==========================================================
  // Helpers.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    ws <= 1'b1;
    @(posedge clk);
    ws <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    addr <= a;
    rs <= 1'b1;
    @(posedge clk);
    rs <= 1'b0;
    #1 d = rdat;
  endtask : rd

  task automatic rc(input string nm, input logic [31:0] a, e);
    rd(a);
    chk(nm, e, d);
  endtask : rc

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Clock and watchdog.
  // one clock serves both the bus and the kernel side.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    rst = 1'b1; ws = 1'b0; rs = 1'b0; addr = '0; wd = '0; seed = 32'h0000BCF7; mv = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rc("status", LPSP_STATUS_ADDR, 32'h3);
    rc("control_one", LPSP_CONTROL_ONE_ADDR, 32'h0);
    rc("unmapped", 32'h40005C20, 32'h0);
    chk("idle line", 32'h1, {31'h0, sout});
    wr(LPSP_RX_TIMEOUT_VALUE_ADDR, 32'hFF000014);
    rc("timeout value", LPSP_RX_TIMEOUT_VALUE_ADDR, 32'h14);
    wr(LPSP_CONTROL_ONE_ADDR, 32'h11F);
    repeat (240) @(posedge clk);
    rc("status early", LPSP_STATUS_ADDR, 32'h3);
    repeat (160) @(posedge clk);
    rc("status timeout", LPSP_STATUS_ADDR, 32'h43);
    wr(LPSP_STATUS_ADDR, 32'hFC);
    wr(LPSP_CONTROL_ONE_ADDR, 32'h1F);
    // all three sampling modes; single sample uses a divisor of 15
    for (int m = 0; m < 3; m++) begin
      wr(LPSP_CONTROL_TWO_ADDR, (32'(m) << 16) | 32'(m / 2 * 15));
      u_peer.bt = (m == 1) ? 8 : 16;
      // gap, bit 0 compensation and stop count per mode; two stop bits in single-sample mode only
      wr(LPSP_TX_GAP_VALUE_ADDR, 32'(2 * m));
      wr(LPSP_COMP_ADDR, (m == 2) ? 32'h201 : 32'(m));
      wr(LPSP_CONTROL_ONE_ADDR, 32'h1F | (32'(m == 2) << 7));
      for (int i = 0; i < 3; i++) begin
        k = 0;
        do begin
          rd(LPSP_STATUS_ADDR);
          k++;
        end while (d[0] !== 1'b1 && k < 400);
        b = 8'(xs());
        txq.push_back(b);
        wr(LPSP_TX_DATA_ADDR, {24'h0, b});
      end
      k = 0;
      while (u_peer.got_q.size() < 3 && k < 3000) begin
        @(posedge clk);
        k++;
      end
      dl = u_peer.st_q.pop_front();
      for (int i = 0; i < 3; i++) begin
        chk("tx frame", {23'h0, 1'b1, txq.pop_front()}, 32'(u_peer.got_q.pop_front()));
        if (i > 0) begin
          k = u_peer.st_q.pop_front();
          ex = 32'((10 + 2 * m + (m == 2)) * u_peer.bt + (m == 1) - (m == 2));
          chk("tx spacing", ex, 32'(k - dl));
          dl = k;
        end
      end
      wr(LPSP_COMP_ADDR, 32'h0);
      for (int j = 0; j < 6; j++) begin
        dl = j % 4;
        b = 8'(xs()) & 8'((1 << (dl + 5)) - 1);
        if (j == 3) begin
          mv = b;
          wr(LPSP_CHAR_MATCH_VALUE_ADDR, {24'h0, mv});
        end
        wr(LPSP_CONTROL_ONE_ADDR, 32'h7 | (dl << 3) | ((j > 1) << 5) | ((j % 2) << 6));
        u_peer.send(b, dl + 5, j > 1, j % 2, j == 4, j == 5);
        repeat (8) @(posedge clk);
        ex = 32'h7 | ((j == 4) << 4) | ((j == 5) << 3) | ((b == mv) << 7);
        rc("rx status", LPSP_STATUS_ADDR, ex);
        rd(LPSP_RX_DATA_ADDR);
        chk("rx data", {24'h0, b}, d);
        wr(LPSP_STATUS_ADDR, 32'hFC);
      end
      wr(LPSP_CONTROL_ONE_ADDR, 32'h1F);
      b = 8'(xs());
      b2 = 8'(xs());
      u_peer.send(b, 8, 1'b0, 1'b0, 1'b0, 1'b0);
      u_peer.send(b2, 8, 1'b0, 1'b0, 1'b0, 1'b0);
      repeat (8) @(posedge clk);
      ex = 32'h27 | (((b == mv) || (b2 == mv)) << 7);
      rc("overrun status", LPSP_STATUS_ADDR, ex);
      rc("overrun data", LPSP_RX_DATA_ADDR, {24'h0, b});
      wr(LPSP_STATUS_ADDR, 32'hFC);
    end
    u_peer.send(8'h5A, 8, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(LPSP_TX_DATA_ADDR, 32'h0);
    repeat (40) @(posedge clk);
    wr(LPSP_CONTROL_ONE_ADDR, 32'h1E);
    repeat (2) @(posedge clk);
    chk("aborted line", 32'h1, {31'h0, sout});
    rc("status off", LPSP_STATUS_ADDR, 32'h3);
    rc("control_one kept", LPSP_CONTROL_ONE_ADDR, 32'h1E);
    rc("control_two kept", LPSP_CONTROL_TWO_ADDR, 32'h2000F);
    end_of_test();
  end
endmodule : lpsp_port_tb
`default_nettype wire
